// ==== logic/usif_ctl_host.sv ====
`timescale 1ns/10ps
module usif_ctl_host (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // AXI4-Lite write
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq,
    // Flag register side
    usif_link.ctl link
);
    import usif_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic awHeld;
    logic [4:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [1:0] ctrl;
    logic [7:0] enShadow;
    logic [7:0] enOut;
    logic idleSeen;
    logic [1:0] evStat;
    logic [1:0] evEn;
    logic intReqQ;
    logic flagWr;
    logic [7:0] flagWrData;
    logic addrWr;
    logic [6:0] addrWrData;
    usif_loop_e loopSt;

    // ****************************************
    // Write channel decode
    // ****************************************
    // Either order, answered after both
    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire haveAw = awHeld || awTake;
    wire haveW = wHeld || wTake;
    wire loopIdle = loopSt == LP_IDLE;
    // Writes wait while the resume loop owns the flag port
    wire doWrite = haveAw && haveW && loopIdle;
    wire [4:0] wa = awHeld ? awAddr : s_axi_awaddr;
    wire [31:0] wd = wHeld ? wData : s_axi_wdata;
    wire wrCtrl = doWrite && wa == OFS_CTRL;
    wire wrEnable = doWrite && wa == OFS_ENABLE;
    wire wrFlags = doWrite && wa == OFS_FLAGS;
    wire wrEvClr = doWrite && wa == OFS_EVCLR;
    wire wrEvEn = doWrite && wa == OFS_EVEN;
    wire wrAddr = doWrite && wa == OFS_ADDR;
    wire wrMapped = wrCtrl || wrEnable || wrFlags || wrEvClr || wrEvEn || wrAddr;
    wire next_awHeld = haveAw && !doWrite;
    wire next_wHeld = haveW && !doWrite;
    wire next_bvalid = doWrite || (s_axi_bvalid && !s_axi_bready);
    wire resumeStart = wrCtrl && ctrl[CTRL_SUSP] && !wd[CTRL_SUSP];

    // ****************************************
    // Resume loop and event logic
    // ****************************************
    // Keep clearing activity until it reads back zero
    wire loopClear = loopSt == LP_CHECK && link.flags[B_ACT];
    wire loopDone = loopSt == LP_CHECK && !link.flags[B_ACT];
    wire [7:0] actOff = ~(8'h01 << B_ACT);
    wire next_flagWr = wrFlags || loopClear;
    wire [7:0] next_flagWrData = loopClear ? (link.flags & actOff) : wd[7:0];
    wire irqRise = link.intReq && !intReqQ;
    wire [1:0] evSet = {loopDone, irqRise};
    wire [1:0] evKeep = wrEvClr ? (evStat & ~wd[1:0]) : evStat;
    wire [1:0] next_evStat = evKeep | evSet;
    wire [1:0] next_evEn = wrEvEn ? wd[1:0] : evEn;
    // Activity unmask is held back until an idle was seen
    wire [7:0] actGate = idleSeen ? 8'hFF : actOff;

    // ****************************************
    // Read decode
    // ****************************************
    wire arTake = s_axi_arvalid && s_axi_arready;
    wire next_rvalid = arTake || (s_axi_rvalid && !s_axi_rready);
    wire [4:0] ra = s_axi_araddr;
    wire rdMapped = ra[1:0] == 2'h0 && ra <= OFS_ADDR;
    wire [31:0] rdVal = ra == OFS_CTRL ? {30'h0, ctrl} :
                        ra == OFS_ENABLE ? {24'h0, enShadow} :
                        ra == OFS_FLAGS ? {24'h0, link.flags} :
                        ra == OFS_EVSTAT ? {30'h0, evStat} :
                        ra == OFS_EVEN ? {30'h0, evEn} :
                        ra == OFS_ADDR ? {25'h0, link.devAddr} : 32'h0;

    // Write channel handshake
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 5'h00;
            wData <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            if (awTake) awAddr <= s_axi_awaddr;
            if (wTake) wData <= s_axi_wdata;
            s_axi_awready <= !next_awHeld && !next_bvalid;
            s_axi_wready <= !next_wHeld && !next_bvalid;
            s_axi_bvalid <= next_bvalid;
            if (doWrite) s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Read channel handshake
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (arTake) s_axi_rdata <= rdVal;
            if (arTake) s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Controls and strobes to the flag register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl <= CTRL_RESET;
            enShadow <= EN_RESET;
            enOut <= EN_RESET;
            idleSeen <= 1'b0;
            flagWr <= 1'b0;
            flagWrData <= 8'h00;
            addrWr <= 1'b0;
            addrWrData <= ADDR_RESET;
        end else begin
            if (wrCtrl) ctrl <= wd[1:0];
            if (wrEnable) enShadow <= wd[7:0] & EN_WMASK;
            if (link.flags[B_IDLE]) idleSeen <= 1'b1;
            enOut <= enShadow & actGate;
            flagWr <= next_flagWr;
            flagWrData <= next_flagWrData;
            addrWr <= wrAddr;
            if (wrAddr) addrWrData <= wd[6:0];
        end
    end

    // Resume loop: check one cycle after each clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            loopSt <= LP_IDLE;
        end else begin
            case (loopSt)
                LP_IDLE: if (resumeStart) loopSt <= LP_CHECK;
                LP_CHECK: loopSt <= link.flags[B_ACT] ? LP_CLEAR : LP_IDLE;
                LP_CLEAR: loopSt <= LP_CHECK;
                default: loopSt <= LP_IDLE;
            endcase
        end
    end

    // Sticky events, set wins over clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            evStat <= EV_RESET;
            evEn <= EV_RESET;
            intReqQ <= 1'b0;
            irq <= 1'b0;
        end else begin
            evStat <= next_evStat;
            evEn <= next_evEn;
            intReqQ <= link.intReq;
            irq <= |(next_evStat & next_evEn);
        end
    end

    assign link.flagWr = flagWr;
    assign link.flagWrData = flagWrData;
    assign link.enables = enOut;
    assign link.addrWr = addrWr;
    assign link.addrWrData = addrWrData;
    assign link.suspend = ctrl[CTRL_SUSP];
    assign link.usePll = ctrl[CTRL_PLL];
endmodule

// ==== logic/usif_pkg.sv ====
// Functional notes
// - Request line is OR of enabled flags
// - One enable bit per flag position
// - Set flags stay until written zero
// - Writing one forces a flag for debug
// - Bit 7 reads zero; flags reset zero
// - Stall flag sets on sent stall
// - Idle flag after 3 ms idle
// - Transaction flag on done; read status
// - Clearing transaction flag advances status fifo for token transactions only
// - Activity flag on line activity
// - Error flag: read-only OR of enabled errors
// - Activity clear ignored until resynchronised
// - Firmware loops clearing activity after resume
// - Idle until PLL locks when PLL-clocked
// - One activity event per idle period
// - Unmask activity only after idle seen
// - Enables gate only the request line
package usif_pkg;
    // ****************************************
    // Flag register layout
    // ****************************************
    localparam int FLAG_W = 8;
    localparam int B_SOF = 6;
    localparam int B_STALL = 5;
    localparam int B_IDLE = 4;
    localparam int B_TRN = 3;
    localparam int B_ACT = 2;
    localparam int B_ERR = 1;
    localparam int B_RST = 0;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] FLAG_WMASK = 8'h7D;
    localparam logic [7:0] EN_WMASK = 8'h7F;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam int ADDR_W = 7;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int IDLE_TIME_US = 3000;
    localparam int IDLE_CYCLES = IDLE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int SYNC_CYCLES = 4;
    // ****************************************
    // Controller register map
    // ****************************************
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_ENABLE = 5'h04;
    localparam logic [4:0] OFS_FLAGS = 5'h08;
    localparam logic [4:0] OFS_EVSTAT = 5'h0C;
    localparam logic [4:0] OFS_EVCLR = 5'h10;
    localparam logic [4:0] OFS_EVEN = 5'h14;
    localparam logic [4:0] OFS_ADDR = 5'h18;
    localparam int CTRL_SUSP = 0;
    localparam int CTRL_PLL = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int EV_IRQ = 0;
    localparam int EV_RESUMED = 1;
    localparam logic [1:0] EV_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {LP_IDLE, LP_CHECK, LP_CLEAR} usif_loop_e;
endpackage

// ==== logic/usif_link.sv ====
`timescale 1ns/10ps
interface usif_link;
    logic flagWr;
    logic [7:0] flagWrData;
    logic [7:0] enables;
    logic addrWr;
    logic [6:0] addrWrData;
    logic suspend;
    logic usePll;
    logic [7:0] flags;
    logic [6:0] devAddr;
    logic intReq;
    modport dev (
        input flagWr, flagWrData, enables, addrWr, addrWrData, suspend, usePll,
        output flags, devAddr, intReq
    );
    modport ctl (
        output flagWr, flagWrData, enables, addrWr, addrWrData, suspend, usePll,
        input flags, devAddr, intReq
    );
endinterface

// ==== logic/usif_flags_dev.sv ====
`timescale 1ns/10ps
module usif_flags_dev #(
    parameter int IDLE_CYCLES_P = usif_pkg::IDLE_CYCLES,
    parameter int SYNC_CYCLES_P = usif_pkg::SYNC_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register side toward the controller
    usif_link.dev link,
    // Engine events
    input wire logic sofRx,
    input wire logic stallTx,
    input wire logic busIdle,
    input wire logic lineActivity,
    input wire logic trnDone,
    input wire logic trnTokenData,
    input wire logic busResetDet,
    // Error layer
    input wire logic [usif_pkg::FLAG_W-1:0] errFlags,
    input wire logic [usif_pkg::FLAG_W-1:0] errEnables,
    // Clock source
    input wire logic pllLocked,
    // Engine results
    output logic fifoAdvance,
    output logic usbIrq,
    output logic [usif_pkg::ADDR_W-1:0] deviceAddr
);
    import usif_pkg::*;

    localparam int CW = $clog2(IDLE_CYCLES_P + 1);
    localparam int SW = $clog2(SYNC_CYCLES_P + 1);

    // ****************************************
    // State
    // ****************************************
    logic [7:0] flags;
    logic [7:0] enables;
    logic [CW-1:0] idleCnt;
    logic [SW-1:0] syncCnt;
    logic actArmed;
    logic trnIsToken;
    logic errAny;

    // ****************************************
    // Operating condition
    // ****************************************
    // Engine is dead while suspended or waiting for the PLL
    wire clockGood;
    wire operational;
    assign clockGood = !link.usePll || pllLocked;
    assign operational = !link.suspend && clockGood;

    // ****************************************
    // Idle detection
    // ****************************************
    // Fires once, on the cycle the idle count reaches its limit
    wire idleHit;
    wire idleFull;
    assign idleFull = idleCnt == CW'(IDLE_CYCLES_P);
    assign idleHit = busIdle && idleCnt == CW'(IDLE_CYCLES_P - 1);

    // Count continuous idle, restart on any traffic
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            idleCnt <= '0;
        end else if (!busIdle) begin
            idleCnt <= '0;
        end else if (!idleFull) begin
            idleCnt <= idleCnt + CW'(1);
        end
    end

    // ****************************************
    // Activity arming
    // ****************************************
    // Only one activity event per idle period
    wire actSet;
    assign actSet = lineActivity && actArmed;

    // Armed by idle, spent by the first activity seen
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            actArmed <= 1'b0;
        end else if (idleHit) begin
            actArmed <= 1'b1;
        end else if (actSet) begin
            actArmed <= 1'b0;
        end
    end

    // ****************************************
    // Wake synchronisation
    // ****************************************
    // Activity clears wait for the count to drain;
    // count frozen while PLL-clocked and the PLL is unlocked
    wire syncDone;
    wire actClearOk;
    assign syncDone = syncCnt == '0;
    assign actClearOk = syncDone && !link.suspend;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            syncCnt <= SW'(SYNC_CYCLES_P);
        end else if (link.suspend) begin
            syncCnt <= SW'(SYNC_CYCLES_P);
        end else if (!syncDone && clockGood) begin
            syncCnt <= syncCnt - SW'(1);
        end
    end

    // ****************************************
    // Hardware set terms
    // ****************************************
    // Hardware sets win over a clear in the same cycle
    wire [7:0] hwSet;
    assign hwSet[7] = 1'b0;
    assign hwSet[B_SOF] = operational && sofRx;
    assign hwSet[B_STALL] = operational && stallTx;
    assign hwSet[B_IDLE] = idleHit;
    assign hwSet[B_TRN] = operational && trnDone;
    assign hwSet[B_ACT] = actSet;
    assign hwSet[B_ERR] = errAny;
    assign hwSet[B_RST] = operational && busResetDet;

    // ****************************************
    // Software write path
    // ****************************************
    // Written value replaces writable bits: zero clears, one sets
    wire [7:0] swVal;
    wire [7:0] actHold;
    wire [7:0] next_flags;
    wire [7:0] next_enables;
    assign swVal = (link.flagWr ? link.flagWrData : flags) & FLAG_WMASK;
    // Early activity clears are swallowed, firmware must retry
    assign actHold = (flags[B_ACT] && !actClearOk) ? (8'h01 << B_ACT) : 8'h00;
    // Bit 1 comes only from the error layer, bit 7 never sets
    assign next_flags = swVal | hwSet | actHold;
    assign next_enables = link.enables & EN_WMASK;

    // Clearing a completed token transaction pops the status fifo
    wire trnClear;
    assign trnClear = link.flagWr && flags[B_TRN] && !link.flagWrData[B_TRN];

    // ****************************************
    // Request line
    // ****************************************
    // Enables only gate the request, flags keep setting
    wire next_irq;
    assign next_irq = |(next_flags & next_enables);

    // ****************************************
    // Registers
    // ****************************************
    // Flag and enable registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flags <= FLAG_RESET;
            enables <= EN_RESET;
            usbIrq <= 1'b0;
        end else begin
            flags <= next_flags;
            enables <= next_enables;
            usbIrq <= next_irq;
        end
    end

    // Registered error summary
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            errAny <= 1'b0;
        end else begin
            errAny <= |(errFlags & errEnables);
        end
    end

    // Token kind of the pending transaction
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            trnIsToken <= 1'b0;
        end else if (hwSet[B_TRN]) begin
            trnIsToken <= trnTokenData;
        end
    end

    // Status fifo advance strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fifoAdvance <= 1'b0;
        end else begin
            fifoAdvance <= trnClear && trnIsToken;
        end
    end

    // Device address, bus reset first
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            deviceAddr <= ADDR_RESET;
        end else if (hwSet[B_RST]) begin
            deviceAddr <= ADDR_RESET;
        end else if (link.addrWr) begin
            deviceAddr <= link.addrWrData;
        end
    end

    // ****************************************
    // Readback toward the controller
    // ****************************************
    assign link.flags = flags;
    assign link.devAddr = deviceAddr;
    assign link.intReq = usbIrq;
endmodule

// ==== sim/usif_link_properties.sv ====
`timescale 1ns/10ps
module usif_link_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Controller side
    input wire logic flagWr,
    input wire logic [7:0] flagWrData,
    input wire logic [7:0] enables,
    input wire logic addrWr,
    input wire logic [6:0] addrWrData,
    input wire logic suspend,
    input wire logic usePll,
    // Device side
    input wire logic [7:0] flags,
    input wire logic [6:0] devAddr,
    input wire logic intReq
);
    import usif_pkg::*;
    logic actArmed;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // Loose model of activity arming
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            actArmed <= 1'b0;
        end else begin
            actArmed <= flags[B_IDLE] | (actArmed & ~flags[B_ACT]);
        end
    end
    // ********
    // Properties
    // ********
    bit_seven_a: assert property (flags[7] == 1'b0)
        else $error("flag bit 7 set");
    irq_or_gate_a: assert property ($stable(enables) |-> intReq == (|(flags & enables & EN_WMASK)))
        else $error("request line wrong");
    write_sets_a: assert property (flagWr |=> (($past(flagWrData) & ~flags & FLAG_WMASK) == 8'h00))
        else $error("written one did not set flag");
    flag_sticky_a: assert property (!flagWr |=> (($past(flags) & ~flags & FLAG_WMASK) == 8'h00))
        else $error("flag cleared without a write");
    act_once_a: assert property ($rose(flags[B_ACT]) && !$past(flagWr & flagWrData[B_ACT]) |-> actArmed)
        else $error("activity flag rose without idle");
    act_susp_a: assert property (suspend && flags[B_ACT] |=> flags[B_ACT])
        else $error("activity cleared while suspended");
    act_sync_a: assert property ($fell(suspend) && flags[B_ACT] |=> flags[B_ACT] [*3])
        else $error("activity cleared before resync");
    bus_rst_addr_a: assert property ($rose(flags[B_RST]) && !$past(flagWr) |-> devAddr == 7'h00)
        else $error("bus reset kept device address");
    addr_write_a: assert property (addrWr |=> (devAddr == $past(addrWrData)) || flags[B_RST])
        else $error("device address not written");
    pll_mode_c: cover property (usePll && !suspend);
endmodule

// ==== sim/test_usb_status_interrupt_flags.sv ====
`timescale 1ns/10ps
module test_usb_status_interrupt_flags;
    import usif_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic [4:0] awAddr = 5'h00, arAddr = 5'h00, evt = 5'h00;
    logic [31:0] wData = 32'h0;
    logic busIdle = 1'b0, tokData = 1'b0, pllLocked = 1'b1;
    logic [7:0] errFl = 8'h00, errEn = 8'h00;
    logic awReady, wReady, bValid, arReady, rValid, irq, fifoAdv, usbIrq;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [6:0] devAddrOut;
    int n_mismatch = 0, num_checks = 0, nAdv = 0;
    usif_link i_usif_link ();
    // 50 ns period
    always #25 clk_sys = ~clk_sys;
    // Count status queue advances
    always @(posedge clk_sys) begin
        if (fifoAdv === 1'b1) begin
            nAdv++;
        end
    end
    // Short idle count
    usif_flags_dev #(.IDLE_CYCLES_P(20), .SYNC_CYCLES_P(4)) i_usif_flags_dev (
        .clk_sys,
        .rstn,
        .link(i_usif_link),
        .sofRx(evt[0]),
        .stallTx(evt[1]),
        .busIdle,
        .lineActivity(evt[4]),
        .trnDone(evt[2]),
        .trnTokenData(tokData),
        .busResetDet(evt[3]),
        .errFlags(errFl),
        .errEnables(errEn),
        .pllLocked,
        .fifoAdvance(fifoAdv),
        .usbIrq,
        .deviceAddr(devAddrOut)
    );
    usif_ctl_host i_usif_ctl_host (
        .clk_sys,
        .rstn,
        .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid),
        .s_axi_awready(awReady),
        .s_axi_wdata(wData),
        .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid),
        .s_axi_wready(wReady),
        .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid),
        .s_axi_bready(bReady),
        .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid),
        .s_axi_arready(arReady),
        .s_axi_rdata(rData),
        .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid),
        .s_axi_rready(rReady),
        .irq,
        .link(i_usif_link)
    );
    usif_link_properties i_usif_link_properties (
        .clk_sys,
        .rstn,
        .flagWr(i_usif_link.flagWr),
        .flagWrData(i_usif_link.flagWrData),
        .enables(i_usif_link.enables),
        .addrWr(i_usif_link.addrWr),
        .addrWrData(i_usif_link.addrWrData),
        .suspend(i_usif_link.suspend),
        .usePll(i_usif_link.usePll),
        .flags(i_usif_link.flags),
        .devAddr(i_usif_link.devAddr),
        .intReq(i_usif_link.intReq)
    );
    // ********
    // Helpers
    // ********
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // One-cycle engine event
    task automatic pulse(input int i);
        evt[i] <= 1'b1;
        @(posedge clk_sys);
        evt[i] <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Each channel released on its own ready
    task automatic axiWr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        bit aw = 1'b0, w = 1'b0;
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_sys);
            if (!aw && awReady === 1'b1) begin
                aw = 1'b1;
                awValid <= 1'b0;
            end
            if (!w && wReady === 1'b1) begin
                w = 1'b1;
                wValid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (bValid !== 1'b1);
        bReady <= 1'b0;
        check("bresp", 32'(er), 32'(bResp));
    endtask
    task automatic axiRd(input logic [4:0] a, input logic [31:0] e, input string nm, input logic [1:0] er = RESP_OKAY);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge clk_sys); while (arReady !== 1'b1);
        arValid <= 1'b0;
        do @(posedge clk_sys); while (rValid !== 1'b1);
        rReady <= 1'b0;
        check(nm, e, rData);
        check("rresp", 32'(er), 32'(rResp));
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_reset;
        axiRd(OFS_FLAGS, 32'h0, "flags");
        axiRd(OFS_ENABLE, 32'h0, "enable");
        axiRd(5'h1C, 32'h0, "unmapped", RESP_SLVERR);
        axiWr(OFS_EVSTAT, 32'h1, RESP_SLVERR);
        axiWr(OFS_ENABLE, 32'h4);
        tick(2);
        check("gated", 32'h0, 32'(i_usif_link.enables));
        $display("t_reset done");
    endtask
    // Events, then set and clear
    task automatic t_events;
        int bits [4] = '{B_SOF, B_STALL, B_TRN, B_RST};
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            axiRd(OFS_FLAGS, 32'h1 << bits[i], "event");
            axiWr(OFS_FLAGS, 32'h0);
        end
        check("usbIrq", 32'h0, 32'(usbIrq));
        pulse(0);
        axiWr(OFS_FLAGS, 32'h40);
        axiRd(OFS_FLAGS, 32'h40, "kept");
        axiWr(OFS_FLAGS, 32'hFF);
        axiRd(OFS_FLAGS, 32'h7D, "forced");
        axiWr(OFS_FLAGS, 32'h0);
        axiRd(OFS_FLAGS, 32'h0, "cleared");
        $display("t_events done");
    endtask
    task automatic t_irq;
        axiWr(OFS_ENABLE, 32'hFF);
        axiRd(OFS_ENABLE, 32'h7F, "enable");
        axiWr(OFS_ENABLE, 32'h20);
        axiWr(OFS_FLAGS, 32'h40);
        tick(3);
        check("usbIrq", 32'h0, 32'(usbIrq));
        pulse(1);
        tick(2);
        check("usbIrq", 32'h1, 32'(usbIrq));
        axiWr(OFS_EVEN, 32'h1);
        tick(2);
        check("irq", 32'h1, 32'(irq));
        axiWr(OFS_EVEN, 32'h0);
        tick(2);
        check("irq", 32'h0, 32'(irq));
        axiWr(OFS_EVCLR, 32'h1);
        axiRd(OFS_EVSTAT, 32'h0, "evstat");
        axiWr(OFS_FLAGS, 32'h0);
        axiWr(OFS_ENABLE, 32'h0);
        $display("t_irq done");
    endtask
    // Enabled errors only
    task automatic t_error;
        errFl <= 8'h04;
        tick(3);
        axiRd(OFS_FLAGS, 32'h0, "masked");
        errEn <= 8'h04;
        tick(3);
        axiWr(OFS_FLAGS, 32'h0);
        axiRd(OFS_FLAGS, 32'h2, "no clear");
        errEn <= 8'h00;
        tick(3);
        axiWr(OFS_FLAGS, 32'h2);
        axiRd(OFS_FLAGS, 32'h0, "no set");
        errFl <= 8'h00;
        $display("t_error done");
    endtask
    task automatic t_busreset;
        axiWr(OFS_ADDR, 32'h55);
        tick(1);
        check("deviceAddr", 32'h55, 32'(devAddrOut));
        pulse(3);
        axiRd(OFS_ADDR, 32'h0, "addr");
        axiRd(OFS_FLAGS, 32'h1, "reset flag");
        axiWr(OFS_FLAGS, 32'h0);
        $display("t_busreset done");
    endtask
    // Only token transactions advance
    task automatic t_fifo;
        int base;
        base = nAdv;
        tokData <= 1'b1;
        pulse(2);
        axiWr(OFS_FLAGS, 32'h0);
        tick(2);
        check("advance", base + 1, nAdv);
        tokData <= 1'b0;
        pulse(2);
        axiWr(OFS_FLAGS, 32'h0);
        tick(2);
        check("advance", base + 1, nAdv);
        $display("t_fifo done");
    endtask
    task automatic t_idle;
        busIdle <= 1'b1;
        tick(19);
        busIdle <= 1'b0;
        axiRd(OFS_FLAGS, 32'h0, "idle short");
        busIdle <= 1'b1;
        tick(20);
        busIdle <= 1'b0;
        axiRd(OFS_FLAGS, 32'h10, "idle");
        pulse(4);
        axiRd(OFS_FLAGS, 32'h14, "activity");
        axiWr(OFS_FLAGS, 32'h0);
        pulse(4);
        axiRd(OFS_FLAGS, 32'h0, "once");
        $display("t_idle done");
    endtask
    // Suspend, resume, lock wait
    task automatic t_suspend;
        busIdle <= 1'b1;
        tick(21);
        busIdle <= 1'b0;
        axiWr(OFS_CTRL, 32'h1);
        pulse(4);
        axiWr(OFS_FLAGS, 32'h0);
        axiRd(OFS_FLAGS, 32'h4, "suspended");
        axiWr(OFS_CTRL, 32'h0);
        axiWr(OFS_EVCLR, 32'h0);
        axiRd(OFS_EVSTAT, 32'h2, "loop");
        axiRd(OFS_FLAGS, 32'h0, "resumed");
        pllLocked <= 1'b0;
        axiWr(OFS_CTRL, 32'h2);
        pulse(0);
        axiRd(OFS_FLAGS, 32'h0, "unlocked");
        pllLocked <= 1'b1;
        tick(2);
        pulse(0);
        axiRd(OFS_FLAGS, 32'h40, "locked");
        $display("t_suspend done");
    endtask
    initial begin
        tick(5);
        rstn <= 1'b1;
        tick(2);
        t_reset();
        t_events();
        t_irq();
        t_error();
        t_busreset();
        t_fifo();
        t_idle();
        t_suspend();
        results();
    end
    // Hang guard
    initial begin
        #1000000;
        n_mismatch++;
        results();
    end
endmodule
